//--- verilog/host_port.sv
/*
  parallel host port of a sampling converter: strobed read and write of a
  13-bit bus with reads narrowable to 8 bits, write-edge strap, sync pin, ready pin.
  assumes the converter core supplies the configuration word, the read
  word and one-cycle begin/end pulses, all on core_clk; every pin is
  asynchronous and is synchronised here. the testbench resolves the wires.
*/
`timescale 1ns/10ps

// Summary of operation
// - strap at power-up picks write latch edge
// - cfg bit 4 set: sync rise starts hold
// - cfg bit 4 clear: sync shows conversion
// - cfg bit 3 picks 8 or 13 read lines; writes always take all 13
// - 13-bit bus, line twelve most significant
// - write buffers on while write and select low
// - drive data while read and select low
// - active-low ready marks function begin and end
module host_port
  import host_port_pkg::*;
#(
  parameter int unsigned DW = host_port_pkg::DATA_W,
  parameter int unsigned NW = host_port_pkg::NARROW_W
) (
  // clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             rst_n,
  // host strobes
  input  wire logic                             cs_n,
  input  wire logic                             rd_n,
  input  wire logic                             wr_n,
  // power-up strap
  input  wire logic                             write_edge_strap,
  // data lines, split into three signals
  input  wire logic [host_port_pkg::DATA_W-1:0] data_in,
  output logic      [host_port_pkg::DATA_W-1:0] data_out,
  output logic      [host_port_pkg::DATA_W-1:0] data_oe,
  // sync pin, split into three signals
  input  wire logic                             sync_in,
  output logic                                  sync_out,
  output logic                                  sync_oe,
  // ready pin
  output logic                                  rdy_n,
  // converter core side
  input  wire logic [host_port_pkg::DATA_W-1:0] cfg_word,
  input  wire logic [host_port_pkg::DATA_W-1:0] rd_word,
  input  wire logic                             conv_begin,
  input  wire logic                             conv_end,
  input  wire logic                             func_begin,
  input  wire logic                             func_end,
  output logic      [host_port_pkg::DATA_W-1:0] wr_word,
  output logic                                  wr_pulse,
  output logic                                  hold_start,
  output logic                                  strap_ready,
  output logic                                  latch_on_fall
);
  import host_port_pkg::*;

  if (DW != DATA_W || NW != NARROW_W || NW > DW) begin : g_bad_width
    $error("host_port: bus widths must be 13 and 8");
  end

  // ***********************************************************************
  // strobe decode, shared by read and write paths
  // ***********************************************************************
  function automatic logic strobe_on(input logic sel_n, input logic stb_n);
    strobe_on = !sel_n && !stb_n;
  endfunction : strobe_on

  // ***********************************************************************
  // pin synchronisation
  // ***********************************************************************
  pin_sync_if #(.W(PIN_W)) pins_if ();

  assign pins_if.raw = {write_edge_strap, sync_in, cs_n, rd_n, wr_n,
                        data_in};

  pin_sync #(
    .W       (PIN_W),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pins     (pins_if.filter)
  );

  logic              cs_n_c, rd_n_c, wr_n_c, sync_c, strap_c;
  logic [DW-1:0]     data_c;

  assign data_c  = pins_if.clean[DW-1:0];
  assign wr_n_c  = pins_if.clean[PIN_WR];
  assign rd_n_c  = pins_if.clean[PIN_RD];
  assign cs_n_c  = pins_if.clean[PIN_CS];
  assign sync_c  = pins_if.clean[PIN_SYNC];
  assign strap_c = pins_if.clean[PIN_STRAP];

  // ***********************************************************************
  // strap capture after reset release
  // ***********************************************************************
  // caught once the synchroniser has filled; later changes are ignored,
  // so a strap moved after the capture has no effect until the next reset
  logic [2:0] strap_cnt_q, strap_cnt_d;
  logic       strap_done_q, strap_done_d;
  logic       fall_mode_q, fall_mode_d;

  always_comb begin
    strap_cnt_d  = strap_cnt_q;
    strap_done_d = strap_done_q;
    fall_mode_d  = fall_mode_q;
    if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_WAIT) begin
        strap_done_d = 1'b1;
        fall_mode_d  = strap_c;
      end else begin
        strap_cnt_d = strap_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q  <= 3'h0;
      strap_done_q <= 1'b0;
      fall_mode_q  <= 1'b0;
    end else begin
      strap_cnt_q  <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      fall_mode_q  <= fall_mode_d;
    end
  end

  // ***********************************************************************
  // write path
  // ***********************************************************************
  logic          wr_act, wr_act_q;
  logic [DW-1:0] wr_hold_q, wr_hold_d;
  logic [DW-1:0] wr_word_q, wr_word_d;
  logic          wr_pulse_q, wr_pulse_d;

  assign wr_act = strobe_on(cs_n_c, wr_n_c);

  always_comb begin
    wr_hold_d  = wr_hold_q;
    wr_word_d  = wr_word_q;
    wr_pulse_d = 1'b0;
    // input buffers only look at the lines inside the window
    if (wr_act) wr_hold_d = data_c;
    if (strap_done_q) begin
      if (fall_mode_q && wr_act && !wr_act_q) begin
        wr_word_d  = data_c;
        wr_pulse_d = 1'b1;
      end else if (!fall_mode_q && !wr_act && wr_act_q) begin
        // last value seen inside the window, so hold time past the
        // rising strobe is not needed
        wr_word_d  = wr_hold_q;
        wr_pulse_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_q   <= 1'b0;
      wr_hold_q  <= DATA_RST;
      wr_word_q  <= DATA_RST;
      wr_pulse_q <= 1'b0;
    end else begin
      wr_act_q   <= wr_act;
      wr_hold_q  <= wr_hold_d;
      wr_word_q  <= wr_word_d;
      wr_pulse_q <= wr_pulse_d;
    end
  end

  // ***********************************************************************
  // read path and data line enables
  // ***********************************************************************
  logic          rd_act;
  logic          wide;
  logic [DW-1:0] data_out_q, data_out_d;
  logic [DW-1:0] data_oe_q, data_oe_d;

  assign rd_act = strobe_on(cs_n_c, rd_n_c);
  assign wide   = cfg_word[CFG_WIDTH_BIT];

  always_comb begin
    data_out_d = data_out_q;
    if (rd_act) data_out_d = rd_word;
  end

  // low lines always join a read, high lines only in wide mode
  for (genvar g = 0; g < DW; g++) begin : g_lane
    if (g < NW) begin : g_low
      assign data_oe_d[g] = rd_act;
    end else begin : g_high
      assign data_oe_d[g] = rd_act && wide;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_q <= DATA_RST;
      data_oe_q  <= '0;
    end else begin
      data_out_q <= data_out_d;
      data_oe_q  <= data_oe_d;
    end
  end

  // ***********************************************************************
  // sync pin
  // ***********************************************************************
  logic sync_in_mode;
  logic sync_prev_q, sync_prev_d;
  logic sync_out_q, sync_out_d;
  logic sync_oe_q, sync_oe_d;
  logic hold_q, hold_d;

  assign sync_in_mode = cfg_word[CFG_SYNC_BIT];

  always_comb begin
    sync_prev_d = sync_c;
    sync_oe_d   = !sync_in_mode;
    hold_d      = sync_in_mode && sync_c && !sync_prev_q;
    sync_out_d  = sync_out_q;
    // a begin in the same cycle as an end wins: the new conversion runs
    if (conv_end) sync_out_d = 1'b0;
    if (conv_begin) sync_out_d = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_q <= 1'b0;
      sync_out_q  <= 1'b0;
      sync_oe_q   <= 1'b0;
      hold_q      <= 1'b0;
    end else begin
      sync_prev_q <= sync_prev_d;
      sync_out_q  <= sync_out_d;
      sync_oe_q   <= sync_oe_d;
      hold_q      <= hold_d;
    end
  end

  // ***********************************************************************
  // ready pin
  // ***********************************************************************
  logic rdy_n_q, rdy_n_d;

  always_comb begin
    rdy_n_d = !(func_begin || func_end);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_n_q <= 1'b1;
    end else begin
      rdy_n_q <= rdy_n_d;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign data_out      = data_out_q;
  assign data_oe       = data_oe_q;
  assign sync_out      = sync_out_q;
  assign sync_oe       = sync_oe_q;
  assign rdy_n         = rdy_n_q;
  assign wr_word       = wr_word_q;
  assign wr_pulse      = wr_pulse_q;
  assign hold_start    = hold_q;
  assign strap_ready   = strap_done_q;
  assign latch_on_fall = fall_mode_q;

endmodule : host_port

//--- common/host_port_pkg.sv
/*
  constants shared by the parallel host port: bus widths, field positions,
  reset values and the pin synchroniser layout.
  assumes a single core clock; the pin_sync_if interface is the only other thing shared between files.
*/
package host_port_pkg;

  // ***********************************************************************
  // data bus
  // ***********************************************************************
  localparam int unsigned DATA_W     = 13;
  localparam int unsigned NARROW_W   = 8;

  // ***********************************************************************
  // configuration word fields
  // ***********************************************************************
  localparam int unsigned CFG_WIDTH_BIT = 3;
  localparam int unsigned CFG_SYNC_BIT  = 4;

  // ***********************************************************************
  // pin bundle layout seen by the synchroniser
  // ***********************************************************************
  localparam int unsigned PIN_WR     = DATA_W;
  localparam int unsigned PIN_RD     = DATA_W + 1;
  localparam int unsigned PIN_CS     = DATA_W + 2;
  localparam int unsigned PIN_SYNC   = DATA_W + 3;
  localparam int unsigned PIN_STRAP  = DATA_W + 4;
  localparam int unsigned PIN_W      = DATA_W + 5;

  // strobes and select idle high, data idle low, strap and sync idle low
  localparam logic [PIN_W-1:0] PIN_RST = 18'h0e000;

  // ***********************************************************************
  // reset values and timing counts
  // ***********************************************************************
  localparam logic [DATA_W-1:0] DATA_RST = 13'h0000;
  localparam int unsigned SYNC_DEPTH     = 3;
  // clean value settles one edge after the third stage has filled
  localparam logic [2:0]  STRAP_WAIT     = 3'h4;
  localparam int unsigned CLK_PERIOD_NS  = 50;

endpackage : host_port_pkg

//--- common/pin_sync_if.sv
/*
  carrier between the port logic and its pin synchroniser.
  assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface pin_sync_if #(
  parameter int unsigned W = 18
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport filter (input raw, output clean);
  modport user   (output raw, input clean);
endinterface : pin_sync_if

//--- verilog/pin_sync.sv
/*
  three-stage synchroniser for a bundle of pins; a bit of the clean
  value changes only once stages two and three agree.
  assumes raw pins are asynchronous to core_clk.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned  W       = 18,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // pins in, filtered value out
  pin_sync_if.filter      pins
);

  logic [W-1:0] s1_q, s2_q, s3_q, clean_q;
  logic [W-1:0] clean_d;

  if (W < 1) begin : g_bad_width
    $error("pin_sync: width must be at least one");
  end

  // ***********************************************************************
  // stage one is read by stage two only
  // ***********************************************************************
  always_comb begin
    clean_d = clean_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) clean_d[i] = s3_q[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q    <= RST_VAL;
      s2_q    <= RST_VAL;
      s3_q    <= RST_VAL;
      clean_q <= RST_VAL;
    end else begin
      s1_q    <= pins.raw;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      clean_q <= clean_d;
    end
  end

  assign pins.clean = clean_q;

endmodule : pin_sync

//--- sim/host_port_properties.sv
/*
  port checker for the parallel host port, bound into host_port.
  assumes one core clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module host_port_checker
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic                              core_clk,
  input wire logic                              rst_n,
  // host strobes
  input wire logic                              cs_n,
  input wire logic                              rd_n,
  input wire logic                              wr_n,
  // core and pin side
  input wire logic [host_port_pkg::DATA_W-1:0]  cfg_word,
  input wire logic [host_port_pkg::DATA_W-1:0]  data_oe,
  input wire logic                              sync_oe,
  input wire logic                              sync_out,
  input wire logic                              conv_begin,
  input wire logic                              conv_end,
  input wire logic                              func_begin,
  input wire logic                              func_end,
  input wire logic                              rdy_n,
  input wire logic                              wr_pulse,
  input wire logic                              hold_start,
  input wire logic                              strap_ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // *****
  // assertions
  // *****
  a_ready_after_func: assert property (
    func_begin || func_end |=> !rdy_n) else $error("ready missed");
  a_ready_cause: assert property (
    !rdy_n |-> $past(func_begin) || $past(func_end))
    else $error("ready without cause");
  a_sync_begin: assert property (
    !cfg_word[4] && conv_begin |=> sync_out) else $error("sync not high");
  a_sync_end: assert property (
    !cfg_word[4] && conv_end && !conv_begin |=> !sync_out)
    else $error("sync not low");
  // first edge after release still sees the reset value
  a_sync_dir: assert property (
    $past(rst_n) |-> sync_oe == !$past(cfg_word[4]))
    else $error("sync direction wrong");
  a_hold_mode: assert property (
    hold_start |-> $past(cfg_word[4]) ##1 !hold_start)
    else $error("hold pulse wrong");
  a_wide_lanes: assert property (
    $past(cfg_word[3]) && data_oe[0] |-> data_oe == 13'h1fff)
    else $error("wide lanes off");
  a_narrow_lanes: assert property (
    !$past(cfg_word[3]) |-> data_oe[12:8] == 5'h00)
    else $error("high lanes driven");
  a_read_gate: assert property (
    (cs_n || rd_n) [*6] |=> data_oe == 13'h0000)
    else $error("bus driven while idle");
  a_write_gate: assert property (
    (cs_n || wr_n) [*8] |=> !wr_pulse) else $error("stray write");
  a_write_strap: assert property (
    wr_pulse |-> strap_ready) else $error("write before strap");
  c_write: cover property (wr_pulse);
  c_hold: cover property (hold_start);
  c_ready: cover property ($fell(rdy_n));
endmodule : host_port_checker

bind host_port host_port_checker i_host_port_checker (
  .core_clk, .rst_n, .cs_n, .rd_n, .wr_n, .cfg_word, .data_oe, .sync_oe,
  .sync_out, .conv_begin, .conv_end, .func_begin, .func_end, .rdy_n,
  .wr_pulse, .hold_start, .strap_ready
);

//--- sim/host_bus_model.sv
/*
  host bus master model: strobed reads and writes, data wire resolution.
  assumes inputs change at the falling edge of core_clk.
*/
`timescale 1ns/10ps
module host_bus_model
  import host_port_pkg::*;
(
  // clock
  input  wire logic                              core_clk,
  // strobes
  output logic                                   cs_n,
  output logic                                   rd_n,
  output logic                                   wr_n,
  // data wire
  input  wire logic [host_port_pkg::DATA_W-1:0]  data_out,
  input  wire logic [host_port_pkg::DATA_W-1:0]  data_oe,
  output logic      [host_port_pkg::DATA_W-1:0]  data_in
);
  logic [DATA_W-1:0] drv_q;
  logic              drv_on;
  // released lines show the inverse, so a stale value never passes
  assign data_in = data_oe & data_out |
                   ~data_oe & (drv_on ? drv_q : ~drv_q);
  initial begin
    {cs_n, rd_n, wr_n} = 3'h7;
    drv_on = 1'b0;
    drv_q = '0;
  end
  task automatic write_word(input logic [DATA_W-1:0] w, input logic sel);
    @(negedge core_clk);
    drv_q = w;
    drv_on = 1'b1;
    cs_n = ~sel;
    wr_n = 1'b0;
    repeat (6) @(negedge core_clk);
    {cs_n, wr_n} = 2'h3; // data outlives the strobe
    @(negedge core_clk);
    drv_on = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask : write_word
  task automatic read_word(output logic [DATA_W-1:0] r, input logic sel);
    @(negedge core_clk);
    cs_n = ~sel;
    rd_n = 1'b0;
    repeat (6) @(negedge core_clk);
    r = data_in;
    {cs_n, rd_n} = 2'h3;
    repeat (8) @(negedge core_clk);
  endtask : read_word
endmodule : host_bus_model

//--- sim/test_host_port.sv
/*
  self-checking bench for host_port with the host bus model.
  assumes the checker is bound in; stimulus moves at falling edges.
*/
`timescale 1ns/10ps
module test_host_port
  import host_port_pkg::*;
;
  localparam logic [DATA_W-1:0] W0 = 13'h1a5c;
  logic core_clk, rst_n, strap, sync_drv, cs_n, rd_n, wr_n;
  logic conv_begin, conv_end, func_begin, func_end;
  logic sync_out, sync_oe, rdy_n, wr_pulse, hold_start;
  logic strap_ready, latch_on_fall;
  wire logic sync_in;
  logic [DATA_W-1:0] data_in, data_out, data_oe, cfg_word, rd_word;
  logic [DATA_W-1:0] wr_word, wr_got;
  int fail_count = 0, comparisons = 0, cycles = 0;
  int n_wr = 0, n_rdy = 0, n_hold = 0;

  assign sync_in = sync_oe ? sync_out : sync_drv;
  host_port i_host_port (.core_clk, .rst_n, .cs_n, .rd_n, .wr_n,
    .write_edge_strap(strap), .data_in, .data_out, .data_oe, .sync_in,
    .sync_out, .sync_oe, .rdy_n, .cfg_word, .rd_word, .conv_begin,
    .conv_end, .func_begin, .func_end, .wr_word, .wr_pulse, .hold_start,
    .strap_ready, .latch_on_fall);
  host_bus_model i_host_bus_model (.core_clk, .cs_n, .rd_n, .wr_n,
    .data_out, .data_oe, .data_in);

  // converter clock range belongs to the core; only the port clock runs here
  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  // *****
  // monitors and timeout
  // *****
  always @(posedge core_clk) begin
    cycles++;
    if (wr_pulse === 1'b1) begin
      n_wr++;
      wr_got = wr_word;
    end
    if (rdy_n === 1'b0) n_rdy++;
    if (hold_start === 1'b1) n_hold++;
    if (cycles == 2000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end
  task automatic check(input logic [DATA_W-1:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : pulse
  // *****
  // scenarios
  // *****
  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    strap = s; // steady from reset on
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    check(strap_ready, 1'b1, "strap ready");
    check(latch_on_fall, s, "latch edge");
    $display("reset test done");
  endtask : do_reset
  task automatic t_write(input logic [DATA_W-1:0] w);
    int n0;
    n0 = n_wr;
    i_host_bus_model.write_word(w, 1'b1);
    check(n_wr, n0 + 1, "one write");
    check(wr_got, w, "write word");
    i_host_bus_model.write_word(~w, 1'b0);
    check(n_wr, n0 + 1, "unselected write");
    $display("write test done");
  endtask : t_write
  task automatic t_read();
    logic [DATA_W-1:0] r;
    cfg_word[3] = 1'b1;
    i_host_bus_model.read_word(r, 1'b1);
    check(r, rd_word, "wide read");
    check(data_oe, 13'h0000, "released");
    cfg_word[3] = 1'b0;
    i_host_bus_model.read_word(r, 1'b1);
    check(r, {W0[12:8], rd_word[7:0]}, "narrow read");
    i_host_bus_model.read_word(r, 1'b0);
    check(r, W0, "unselected read");
    $display("read test done");
  endtask : t_read
  task automatic t_sync();
    int n0;
    n0 = n_hold;
    pulse(conv_begin);
    check(sync_in, 1'b1, "sync high");
    repeat (6) @(negedge core_clk);
    check(n_hold, n0, "no hold as output");
    pulse(conv_end);
    check(sync_in, 1'b0, "sync low");
    cfg_word[4] = 1'b1;
    repeat (2) @(negedge core_clk);
    check(sync_oe, 1'b0, "sync input");
    sync_drv = 1'b1;
    repeat (8) @(negedge core_clk);
    check(n_hold, n0 + 1, "hold on rise");
    sync_drv = 1'b0;
    $display("sync test done");
  endtask : t_sync
  task automatic t_ready();
    int n0;
    n0 = n_rdy;
    pulse(func_begin);
    check(n_rdy, n0 + 1, "ready begin");
    pulse(func_end);
    check(n_rdy, n0 + 2, "ready end");
    check(rdy_n, 1'b1, "ready idle");
    $display("ready test done");
  endtask : t_ready
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {strap, sync_drv, conv_begin, conv_end, func_begin, func_end} = '0;
    cfg_word = 13'h0000;
    rd_word = 13'h0b2d;
    do_reset(1'b0);
    t_write(W0);
    t_read();
    t_sync();
    t_ready();
    do_reset(1'b1);
    t_write(13'h0a5a);
    results();
  end
endmodule : test_host_port
